/* File: verilog/host_bus_pkg.sv */
// constants shared by the host bus unit, its lane steering and the test bench
package host_bus_pkg;

    // ========================================================================
    // widths
    localparam int ADDR_W  = 15;   // address pins 15 down to 1
    localparam int DATA_W  = 32;
    localparam int LANES   = 4;
    localparam int BASE_W  = 12;   // compared against address bits 15 to 4
    localparam int STRAP_W = 2;
    localparam int BOOT_W  = 2;

    // ========================================================================
    // bus width strap codes
    localparam logic [1:0] BUS_8  = 2'h0;
    localparam logic [1:0] BUS_16 = 2'h1;
    localparam logic [1:0] BUS_32 = 2'h2;

    // ========================================================================
    // active-low enable patterns, bit n is lane n
    localparam logic [3:0] BE_FULL   = 4'h0;
    localparam logic [3:0] BE_LOW16  = 4'hc;
    localparam logic [3:0] BE_HIGH16 = 4'h3;
    localparam logic [3:0] BE_B0     = 4'he;
    localparam logic [3:0] BE_B1     = 4'hd;
    localparam logic [3:0] BE_B2     = 4'hb;
    localparam logic [3:0] BE_B3     = 4'h7;
    localparam logic [1:0] BE_UPPER_OFF = 2'h3;

    // ========================================================================
    // internal lane masks, active high
    localparam logic [3:0] LN_NONE = 4'h0;
    localparam logic [3:0] LN_ALL  = 4'hf;
    localparam logic [3:0] LN_LOW  = 4'h3;
    localparam logic [3:0] LN_HIGH = 4'hc;
    localparam logic [3:0] LN_0    = 4'h1;
    localparam logic [3:0] LN_1    = 4'h2;
    localparam logic [3:0] LN_2    = 4'h4;
    localparam logic [3:0] LN_3    = 4'h8;

    // ========================================================================
    // reset values and the final boot count
    localparam logic [31:0] DATA_RST  = 32'h0;
    localparam logic [14:0] ADDR_RST  = 15'h0;
    localparam logic [3:0]  OE_N_RST  = 4'hf;
    localparam logic [1:0]  BOOT_DONE = 2'h3;

    // ========================================================================
    // transfer sequencer
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h1,
        ST_ACCESS = 3'h2,
        ST_HOLD   = 3'h4
    } xfer_state_t;

endpackage : host_bus_pkg

/* File: verilog/pin_sync.sv */
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_t;

    sync_state_t cur_ff;
    sync_state_t nxt_ff;

    // the first stage feeds only the second one
    always_comb begin
        nxt_ff      = cur_ff;
        nxt_ff.meta = din;
        nxt_ff.sync = cur_ff.meta;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= {RST_VAL, RST_VAL};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign dout = cur_ff.sync;

endmodule : pin_sync
`default_nettype wire

/* File: verilog/lane_steer.sv */
// byte enable decode into internal lanes, with word swap for narrow buses
`timescale 1ns/100ps
`default_nettype none
module lane_steer (
    // captured access attributes and the live queue data select
    input  wire logic [3:0] enable_n,
    input  wire logic [1:0] bus_width,
    input  wire logic       queue_data_select_n,
    input  wire logic       half_sel,
    // decode result
    output logic      [3:0] lanes,
    output logic            swap,
    output logic            ok
);

    logic       wide;
    logic       mid;
    logic       upper;
    logic [3:0] be_eff;

    always_comb begin
        wide  = (bus_width == host_bus_pkg::BUS_32);
        mid   = (bus_width == host_bus_pkg::BUS_16);
        // narrow buses reach the upper half only through the word swap
        upper = half_sel && !wide;
        // upper enables are not wired on narrow buses
        be_eff = wide ? enable_n
                      : {host_bus_pkg::BE_UPPER_OFF, enable_n[1:0]};
        lanes = host_bus_pkg::LN_NONE;
        swap  = 1'b0;
        if (!queue_data_select_n && wide) begin
            lanes = host_bus_pkg::LN_ALL;
        end else begin
            case (be_eff)
                host_bus_pkg::BE_FULL: begin
                    lanes = host_bus_pkg::LN_ALL;
                end
                host_bus_pkg::BE_LOW16: begin
                    if (wide || mid) begin
                        lanes = upper ? host_bus_pkg::LN_HIGH
                                      : host_bus_pkg::LN_LOW;
                        swap  = upper;
                    end
                end
                host_bus_pkg::BE_HIGH16: begin
                    lanes = host_bus_pkg::LN_HIGH;
                end
                host_bus_pkg::BE_B0: begin
                    lanes = upper ? host_bus_pkg::LN_2
                                  : host_bus_pkg::LN_0;
                    swap  = upper;
                end
                host_bus_pkg::BE_B1: begin
                    lanes = upper ? host_bus_pkg::LN_3
                                  : host_bus_pkg::LN_1;
                    swap  = upper;
                end
                host_bus_pkg::BE_B2: begin
                    lanes = host_bus_pkg::LN_2;
                end
                host_bus_pkg::BE_B3: begin
                    lanes = host_bus_pkg::LN_3;
                end
                default: begin
                    lanes = host_bus_pkg::LN_NONE;
                end
            endcase
        end
        ok = (lanes != host_bus_pkg::LN_NONE);
    end

endmodule : lane_steer
`default_nettype wire

/* File: verilog/host_bus_unit.sv */
// host bus unit: pin capture, lane decode and internal register strobes
//
// Function
// - accept asynchronous and synchronous transfers over separate and common pins
// - synchronous and asynchronous transfers may interleave but never overlap
// - a 32-bit bus allows 8, 16 and 32-bit transfers
// - a 16-bit bus allows 8 and 16-bit transfers only
// - an 8-bit bus allows only 8-bit transfers
// - no byte swap inside a half, but words swap between halves
// - all four enables low gives a 32-bit access, 32-bit bus only
// - enables 0 and 1 low give a low 16-bit access
// - enables 2 and 3 low give a high 16-bit access, 32-bit only
// - a single low enable accesses only its own byte lane
// - queue data select low overrides enables with a 32-bit access, 32-bit bus only
// - enables 2 and 3 count only on a 32-bit bus
// - decode addresses only for host cycles, never DMA cycles
// - address strobe rising edge latches address, qualifier and enables
// - local device hit is qualifier plus address 15:4 against base
// - queue data select on 32-bit bus bypasses decode to queue data
`timescale 1ns/100ps
`default_nettype none
module host_bus_unit (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // common host pins
    input  wire logic [14:0] addr_lines,
    input  wire logic        addr_valid_qualifier,
    input  wire logic        lane0_enable_n,
    input  wire logic        lane1_enable_n,
    input  wire logic        lane2_enable_n,
    input  wire logic        lane3_enable_n,
    input  wire logic        addr_strobe_n,
    input  wire logic        queue_data_select_n,
    input  wire logic [31:0] host_data_lines_in,
    output logic      [31:0] host_data_lines_out,
    output logic      [3:0]  host_data_lines_oe_n,
    output logic             local_device_hit_n,
    // asynchronous transfer pins
    input  wire logic        async_read_n,
    input  wire logic        async_write_n,
    // synchronous transfer pins
    input  wire logic        sync_cycle_n,
    input  wire logic        sync_write,
    // configuration strap
    input  wire logic [1:0]  bus_width_strap,
    // internal register side
    input  wire logic [11:0] base_addr,
    input  wire logic [31:0] reg_rdata,
    output logic      [14:0] reg_addr,
    output logic      [3:0]  reg_lanes,
    output logic      [31:0] reg_wdata,
    output logic             reg_write,
    output logic             reg_read,
    output logic             queue_data_access,
    output logic             overlap_error
);

    // ========================================================================
    // pin synchronisation
    localparam int SYNC_W = 2 * host_bus_pkg::ADDR_W + 1 + 4 + 1 + 1 + 4
                            + host_bus_pkg::STRAP_W + host_bus_pkg::DATA_W
                            - host_bus_pkg::ADDR_W;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic [14:0]       addr_s;
    logic              aen_s;
    logic [3:0]        be_n_s;
    logic              ads_n_s;
    logic              dcs_n_s;
    logic              rd_n_s;
    logic              wr_n_s;
    logic              cyc_n_s;
    logic              swr_s;
    logic [1:0]        strap_s;
    logic [31:0]       data_s;

    assign pins_raw = {addr_lines, addr_valid_qualifier,
                       lane3_enable_n, lane2_enable_n,
                       lane1_enable_n, lane0_enable_n,
                       addr_strobe_n, queue_data_select_n,
                       async_read_n, async_write_n, sync_cycle_n, sync_write,
                       bus_width_strap, host_data_lines_in};

    pin_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL ({SYNC_W{1'b1}})
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     (pins_raw),
        .dout    (pins_s)
    );

    assign {addr_s, aen_s, be_n_s, ads_n_s, dcs_n_s, rd_n_s, wr_n_s,
            cyc_n_s, swr_s, strap_s, data_s} = pins_s;

    // ========================================================================
    // state
    typedef struct packed {
        host_bus_pkg::xfer_state_t st;
        logic [1:0]  boot;
        logic [1:0]  bus_w;
        logic        ads_prev;
        logic [14:0] lat_addr;
        logic        lat_aen;
        logic [3:0]  lat_be_n;
        logic        lat_hit;
        logic        is_read;
        logic        swap;
        logic        hit_n;
        logic [31:0] dout;
        logic [3:0]  oe_n;
        logic [14:0] addr;
        logic [3:0]  lanes;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
        logic        queue;
        logic        overlap;
    } hbu_state_t;

    hbu_state_t cur_ff;
    hbu_state_t nxt_ff;

    // ========================================================================
    // decode
    logic       req_async;
    logic       req_sync;
    logic       go;
    logic       bypass;
    logic       live_hit;
    logic [3:0] dec_lanes;
    logic       dec_swap;
    logic       dec_ok;

    // asynchronous strobes and the synchronous cycle share the common pins
    assign req_async = !rd_n_s || !wr_n_s;
    assign req_sync  = !cyc_n_s;
    assign go        = req_async ^ req_sync;
    // the bypass uses the live select: it counts while it is held low
    assign bypass    = !dcs_n_s && (cur_ff.bus_w == host_bus_pkg::BUS_32);
    // only a host cycle (qualifier low) may decode, DMA cycles never hit
    assign live_hit  = !aen_s && (addr_s[14:3] == base_addr);

    lane_steer u_lane_steer (
        .enable_n            (cur_ff.lat_be_n),
        .bus_width           (cur_ff.bus_w),
        .queue_data_select_n (dcs_n_s),
        .half_sel            (cur_ff.lat_addr[0]),
        .lanes               (dec_lanes),
        .swap                (dec_swap),
        .ok                  (dec_ok)
    );

    // ========================================================================
    // next state
    always_comb begin
        nxt_ff          = cur_ff;
        nxt_ff.wr       = 1'b0;
        nxt_ff.rd       = 1'b0;
        nxt_ff.ads_prev = ads_n_s;
        nxt_ff.hit_n    = !live_hit;
        nxt_ff.overlap  = req_async && req_sync;
        // strap is caught once the synchroniser holds the real level
        if (cur_ff.boot != host_bus_pkg::BOOT_DONE) begin
            nxt_ff.boot = cur_ff.boot + 2'h1;
            if (cur_ff.boot == host_bus_pkg::BOOT_DONE - 2'h1) begin
                nxt_ff.bus_w = strap_s;
            end
        end
        if (!cur_ff.ads_prev && ads_n_s) begin
            nxt_ff.lat_addr = addr_s;
            nxt_ff.lat_aen  = aen_s;
            nxt_ff.lat_be_n = be_n_s;
            nxt_ff.lat_hit  = !aen_s && (addr_s[14:3] == base_addr);
        end
        unique case (cur_ff.st)
            host_bus_pkg::ST_IDLE: begin
                if (go && cur_ff.boot == host_bus_pkg::BOOT_DONE) begin
                    nxt_ff.st = host_bus_pkg::ST_HOLD;
                    // rejected patterns fall through to hold, nothing moves
                    if (dec_ok && (bypass || cur_ff.lat_hit)) begin
                        nxt_ff.st      = host_bus_pkg::ST_ACCESS;
                        nxt_ff.is_read = req_async ? !rd_n_s : !swr_s;
                        nxt_ff.wr      = req_async ? rd_n_s : swr_s;
                        nxt_ff.rd      = req_async ? !rd_n_s : !swr_s;
                        nxt_ff.swap    = dec_swap;
                        nxt_ff.lanes   = dec_lanes;
                        nxt_ff.queue   = bypass;
                        nxt_ff.addr    = cur_ff.lat_addr;
                        nxt_ff.wdata   = dec_swap
                            ? {data_s[15:0], data_s[15:0]}
                            : data_s;
                    end
                end
            end
            host_bus_pkg::ST_ACCESS: begin
                nxt_ff.st = host_bus_pkg::ST_HOLD;
                if (cur_ff.is_read) begin
                    nxt_ff.dout = cur_ff.swap
                        ? {reg_rdata[31:16], reg_rdata[31:16]}
                        : reg_rdata;
                    // a swapped read appears on the low pins of the host
                    nxt_ff.oe_n = cur_ff.swap
                        ? ~{2'h0, cur_ff.lanes[3:2]}
                        : ~cur_ff.lanes;
                end
            end
            host_bus_pkg::ST_HOLD: begin
                if (!req_async && !req_sync) begin
                    nxt_ff.st   = host_bus_pkg::ST_IDLE;
                    nxt_ff.oe_n = host_bus_pkg::OE_N_RST;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '{st:       host_bus_pkg::ST_IDLE,
                        boot:     '0,
                        bus_w:    host_bus_pkg::BUS_8,
                        ads_prev: 1'b1,
                        lat_addr: host_bus_pkg::ADDR_RST,
                        lat_aen:  1'b1,
                        lat_be_n: host_bus_pkg::LN_ALL,
                        lat_hit:  1'b0,
                        is_read:  1'b0,
                        swap:     1'b0,
                        hit_n:    1'b1,
                        dout:     host_bus_pkg::DATA_RST,
                        oe_n:     host_bus_pkg::OE_N_RST,
                        addr:     host_bus_pkg::ADDR_RST,
                        lanes:    host_bus_pkg::LN_NONE,
                        wdata:    host_bus_pkg::DATA_RST,
                        wr:       1'b0,
                        rd:       1'b0,
                        queue:    1'b0,
                        overlap:  1'b0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ========================================================================
    // outputs
    assign host_data_lines_out  = cur_ff.dout;
    assign host_data_lines_oe_n = cur_ff.oe_n;
    assign local_device_hit_n   = cur_ff.hit_n;
    assign reg_addr             = cur_ff.addr;
    assign reg_lanes            = cur_ff.lanes;
    assign reg_wdata            = cur_ff.wdata;
    assign reg_write            = cur_ff.wr;
    assign reg_read             = cur_ff.rd;
    assign queue_data_access    = cur_ff.queue;
    assign overlap_error        = cur_ff.overlap;

    // ========================================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic strobe;
    assign strobe = cur_ff.wr || cur_ff.rd;

    sequence s_start;
        cur_ff.st == host_bus_pkg::ST_IDLE && go
            && cur_ff.boot == host_bus_pkg::BOOT_DONE;
    endsequence

    sequence s_good_start;
        s_start ##0 (dec_ok && (bypass || cur_ff.lat_hit));
    endsequence

    AST_ONE_SOURCE: assert property (
        s_good_start |=> strobe ##1 !strobe)
        else $error("start did not give a single strobe");

    AST_NO_OVERLAP: assert property (
        (req_async && req_sync) |=> overlap_error && !strobe)
        else $error("overlapping transfers were not refused");

    AST_FULL_ON_WIDE: assert property (
        strobe && reg_lanes == host_bus_pkg::LN_ALL && !queue_data_access
            |-> cur_ff.bus_w == host_bus_pkg::BUS_32)
        else $error("32-bit access on a narrow bus");

    AST_MID_NO_FULL: assert property (
        strobe && cur_ff.bus_w == host_bus_pkg::BUS_16
            |-> reg_lanes != host_bus_pkg::LN_ALL)
        else $error("full access on the 16-bit bus");

    AST_BYTE_ONLY: assert property (
        strobe && cur_ff.bus_w == host_bus_pkg::BUS_8 |-> $onehot(reg_lanes))
        else $error("wide access on the 8-bit bus");

    AST_WORD_SWAP: assert property (
        s_good_start ##0 dec_swap && req_async && !wr_n_s
            |=> reg_wdata[31:16] == $past(data_s[15:0])
                && reg_lanes[1:0] == 2'h0)
        else $error("swapped write missed the upper half");

    AST_LOW_WORD: assert property (
        s_good_start ##0 (cur_ff.lat_be_n == host_bus_pkg::BE_LOW16
            && cur_ff.bus_w == host_bus_pkg::BUS_32 && dcs_n_s)
            |=> reg_lanes == host_bus_pkg::LN_LOW)
        else $error("low word access used wrong lanes");

    AST_QUEUE_BYPASS: assert property (
        s_start ##0 bypass |=> queue_data_access
            && reg_lanes == host_bus_pkg::LN_ALL && strobe)
        else $error("queue data select did not force full access");

    AST_DMA_NO_HIT: assert property (
        aen_s |=> local_device_hit_n)
        else $error("hit reported in a DMA cycle");

    AST_STROBE_LATCH: assert property (
        $rose(ads_n_s) |=> cur_ff.lat_addr == $past(addr_s)
            && cur_ff.lat_be_n == $past(be_n_s))
        else $error("address strobe edge did not latch");

    AST_BAD_ENABLES: assert property (
        s_start ##0 !dec_ok |=> !strobe [*2])
        else $error("rejected enables still gave an access");

endmodule : host_bus_unit
`default_nettype wire

/* File: test/host_model.sv */
// host processor model driving the shared and transfer pins of the host port
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // clock and strap
    input  wire logic        ref_clk,
    input  wire logic [1:0]  bus_width,
    // host pins
    output logic      [14:0] addr_lines,
    output logic             addr_valid_qualifier,
    output logic      [3:0]  enable_n,
    output logic             addr_strobe_n,
    output logic             queue_data_select_n,
    output logic      [31:0] host_data_lines_in,
    output logic             async_read_n,
    output logic             async_write_n,
    output logic             sync_cycle_n,
    output logic             sync_write
);
    initial begin
        {addr_lines, addr_valid_qualifier, enable_n} = 20'h0;
        {addr_strobe_n, queue_data_select_n, async_read_n} = 3'h7;
        {async_write_n, sync_cycle_n, sync_write} = 3'h6;
        host_data_lines_in = 32'h0;
    end
    // kind: 0/1 async write/read, 2/3 sync write/read, 4 both at once
    task automatic start(input logic [3:0] be, input logic [14:0] a,
                         input logic q, input logic qs,
                         input logic [2:0] kind, input logic [31:0] hw);
        @(posedge ref_clk);
        addr_lines <= a;
        addr_valid_qualifier <= q;
        enable_n <= be;
        addr_strobe_n <= 1'b0;
        case (bus_width)
            host_bus_pkg::BUS_32: host_data_lines_in <= hw;
            host_bus_pkg::BUS_16: host_data_lines_in <= {~hw[15:0], hw[15:0]};
            default: host_data_lines_in <= {~hw[7:0], ~hw[7:0], {2{hw[7:0]}}};
        endcase
        // fields held steady well before and after the strobe edge
        repeat (3) @(posedge ref_clk);
        addr_strobe_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        queue_data_select_n <= qs;
        async_write_n <= !(kind == 3'd0 || kind == 3'd4);
        async_read_n <= kind != 3'd1;
        sync_cycle_n <= !(kind inside {3'd2, 3'd3, 3'd4});
        sync_write <= kind != 3'd3;
    endtask : start
    task automatic stop();
        @(posedge ref_clk);
        {async_read_n, async_write_n, sync_cycle_n} <= 3'h7;
        queue_data_select_n <= 1'b1;
        // released lines no longer show the written value
        host_data_lines_in <= ~host_data_lines_in;
        repeat (4) @(posedge ref_clk);
    endtask : stop
endmodule : host_model
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the host bus unit lane decode and transfers
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    err_count++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    localparam logic [11:0] BASE = 12'h2a5;
    localparam logic [14:0] HA0  = {BASE, 3'h0};
    localparam logic [14:0] HA1  = {BASE, 3'h1};
    localparam logic [14:0] MISS = {~BASE, 3'h0};
    // ========================================================================
    // signals
    logic        ref_clk, rst_n, qual, strobe_n, qsel_n;
    logic        rd_n, wr_n, cyc_n, swr, hit_n, reg_write, reg_read;
    logic        queue_data_access, overlap_error;
    logic [1:0]  bus_width_strap;
    logic [3:0]  be_n, oe_n, reg_lanes;
    logic [14:0] addr, reg_addr;
    logic [31:0] hd_in, hd_out, reg_rdata, reg_wdata;
    int          err_count = 0, samples_checked = 0;
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        bus_width_strap = host_bus_pkg::BUS_32;
        reg_rdata = 32'h0;
    end
    always #50 ref_clk = ~ref_clk;
    host_model u_host_model (.ref_clk(ref_clk), .bus_width(bus_width_strap),
        .addr_lines(addr), .addr_valid_qualifier(qual), .enable_n(be_n),
        .addr_strobe_n(strobe_n), .queue_data_select_n(qsel_n),
        .host_data_lines_in(hd_in), .async_read_n(rd_n), .async_write_n(wr_n),
        .sync_cycle_n(cyc_n), .sync_write(swr));
    host_bus_unit u_host_bus_unit (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr_lines(addr), .addr_valid_qualifier(qual),
        .lane0_enable_n(be_n[0]), .lane1_enable_n(be_n[1]),
        .lane2_enable_n(be_n[2]), .lane3_enable_n(be_n[3]),
        .addr_strobe_n(strobe_n), .queue_data_select_n(qsel_n),
        .host_data_lines_in(hd_in), .host_data_lines_out(hd_out),
        .host_data_lines_oe_n(oe_n), .local_device_hit_n(hit_n),
        .async_read_n(rd_n), .async_write_n(wr_n), .sync_cycle_n(cyc_n),
        .sync_write(swr), .bus_width_strap(bus_width_strap), .base_addr(BASE),
        .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_lanes(reg_lanes),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .queue_data_access(queue_data_access), .overlap_error(overlap_error));
    function automatic logic [31:0] rd(input logic [14:0] a);
        return {a, 1'b1, ~a, 1'b0};
    endfunction : rd
    function automatic logic [31:0] mask(input logic [3:0] l);
        return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    endfunction : mask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    // strap is only taken just after reset, so each width gets its own reset
    task automatic do_reset(input logic [1:0] w);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        bus_width_strap <= w;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask : do_reset
    // ln of zero means the access must be refused
    task automatic xfer(input logic [3:0] be, input logic [14:0] a,
                        input logic q, input logic qs, input logic [2:0] kind,
                        input logic [31:0] hw, input logic [3:0] ln,
                        input logic [31:0] ex, input logic [3:0] oe);
        logic       seen;
        logic [3:0] lm;
        seen = 1'b0;
        lm = kind[0] ? ~oe : ln;
        reg_rdata <= rd(a);
        u_host_model.start(be, a, q, qs, kind, hw);
        for (int i = 0; i < 10 && !seen; i++) begin
            @(posedge ref_clk);
            #1;
            seen = reg_write | reg_read;
        end
        `CHK(hit_n, !(!q && a[14:3] == BASE))
        if (ln == 4'h0) begin
            `CHK(seen, 1'b0)
            if (kind == 3'd4)
                `CHK(overlap_error, 1'b1)
        end else if (!seen) begin
            err_count++;
            $display("BAD t=%0t no transfer started", $time);
            results();
        end else begin
            `CHK(reg_lanes, ln)
            `CHK(reg_write, !kind[0])
            `CHK(queue_data_access, !qs && bus_width_strap == 2'h2)
            `CHK(reg_addr, a)
            // read data and its enables appear one edge after the pulse
            if (kind[0]) begin
                @(posedge ref_clk);
                #1;
            end
            `CHK(oe_n, oe)
            `CHK((kind[0] ? hd_out : reg_wdata) & mask(lm), ex & mask(lm))
        end
        u_host_model.stop();
    endtask : xfer
    task automatic t_wide();
        logic [3:0] pats [9];
        pats = '{4'h0, 4'hc, 4'h3, 4'he, 4'hd, 4'hb, 4'h7, 4'h5, 4'h9};
        do_reset(host_bus_pkg::BUS_32);
        for (int i = 0; i < 9; i++)
            xfer(pats[i], HA0, 1'b0, 1'b1, 3'd0, 32'h1234_5678 + i,
                 i < 7 ? ~pats[i] : 4'h0, 32'h1234_5678 + i, 4'hf);
        xfer(4'h0, HA0, 1'b0, 1'b1, 3'd1, 0, 4'hf, rd(HA0), 4'h0);
        xfer(4'hb, HA0, 1'b0, 1'b1, 3'd2, 32'h9abc_def0, 4'h4,
             32'h9abc_def0, 4'hf);
        xfer(4'hc, HA0, 1'b0, 1'b1, 3'd3, 0, 4'h3, rd(HA0), 4'hc);
        xfer(4'h0, HA0, 1'b0, 1'b1, 3'd4, 0, 4'h0, 0, 4'hf);
        $display("test wide done");
    endtask : t_wide
    task automatic t_decode();
        xfer(4'h0, HA0, 1'b1, 1'b1, 3'd0, 32'h1, 4'h0, 0, 4'hf);
        xfer(4'h0, MISS, 1'b0, 1'b1, 3'd0, 32'h2, 4'h0, 0, 4'hf);
        xfer(4'hd, MISS, 1'b0, 1'b0, 3'd0, 32'h5566_7788, 4'hf,
             32'h5566_7788, 4'hf);
        xfer(4'h7, HA0, 1'b1, 1'b0, 3'd1, 0, 4'hf, rd(HA0), 4'h0);
        $display("test decode done");
    endtask : t_decode
    task automatic t_mid();
        do_reset(host_bus_pkg::BUS_16);
        xfer(4'hc, HA0, 1'b0, 1'b1, 3'd0, 32'h0000_a1b2, 4'h3,
             32'h0000_a1b2, 4'hf);
        xfer(4'hc, HA1, 1'b0, 1'b1, 3'd0, 32'h0000_c3d4, 4'hc,
             32'hc3d4_c3d4, 4'hf);
        xfer(4'h0, HA0, 1'b0, 1'b1, 3'd0, 32'h11, 4'h3, 32'h11, 4'hf);
        xfer(4'h3, HA0, 1'b0, 1'b1, 3'd0, 32'h22, 4'h0, 0, 4'hf);
        xfer(4'hd, HA0, 1'b0, 1'b1, 3'd0, 32'h7700, 4'h2, 32'h7700, 4'hf);
        xfer(4'he, HA0, 1'b0, 1'b0, 3'd0, 32'h33, 4'h1, 32'h33, 4'hf);
        xfer(4'hc, HA1, 1'b0, 1'b1, 3'd1, 0, 4'hc,
             {2{HA1, 1'b1}}, 4'hc);
        $display("test mid done");
    endtask : t_mid
    task automatic t_narrow();
        do_reset(host_bus_pkg::BUS_8);
        xfer(4'he, HA0, 1'b0, 1'b1, 3'd0, 32'h5c, 4'h1, 32'h5c, 4'hf);
        xfer(4'hd, HA0, 1'b0, 1'b1, 3'd0, 32'h6e, 4'h2, 32'h6e6e, 4'hf);
        xfer(4'hc, HA0, 1'b0, 1'b1, 3'd0, 32'h7f, 4'h0, 0, 4'hf);
        $display("test narrow done");
    endtask : t_narrow
    initial begin
        t_wide();
        t_decode();
        t_mid();
        t_narrow();
        results();
    end
endmodule : tb_top
`default_nettype wire
